// File: verilog/dpss_pkg.sv
`default_nettype none
package dpss_pkg;

    // slave progress through the telegram-acceptance states
    typedef enum logic [2:0] {
        DPSS_ST_PON  = 3'b000,
        DPSS_ST_WPRM = 3'b001,
        DPSS_ST_WCFG = 3'b010,
        DPSS_ST_CHK  = 3'b011,
        DPSS_ST_DXCH = 3'b100
    } dpss_state_e;

    typedef enum logic [3:0] {
        DPSS_TK_DATA    = 4'h0,
        DPSS_TK_RD_INP  = 4'h1,
        DPSS_TK_RD_OUTP = 4'h2,
        DPSS_TK_GLOBAL  = 4'h3,
        DPSS_TK_DIAG    = 4'h4,
        DPSS_TK_CHK_CFG = 4'h5,
        DPSS_TK_SET_PRM = 4'h6,
        DPSS_TK_GET_CFG = 4'h7,
        DPSS_TK_SET_ADR = 4'h8
    } dpss_kind_e;

    typedef enum logic [1:0] {
        DPSS_CR_CORRECT   = 2'h0,
        DPSS_CR_INCORRECT = 2'h1,
        DPSS_CR_ADAPTABLE = 2'h2
    } dpss_chk_e;

    // one decoded telegram from the link layer, valid for one cycle
    typedef struct packed {
        logic valid;
        dpss_kind_e kind;
        logic class2;
        logic [6:0] new_addr;
        logic [7:0] in_bytes;
        logic [7:0] out_bytes;
        logic [15:0] ident;
        logic sync_cap;
        logic freeze_cap;
        logic [15:0] wd_time;
        logic [7:0] prm_len;
    } dpss_tlg_s;

    typedef struct packed {
        logic valid;
        logic accepted;
        dpss_kind_e kind;
    } dpss_rsp_s;

    typedef struct packed {
        logic valid;
        logic [7:0] in_bytes;
        logic [7:0] out_bytes;
    } dpss_cfg_s;

    // standard part of a parameter telegram, in bytes
    localparam logic [7:0] DPSS_PRM_MIN_LEN = 8'h07;
    // arbitrary ident value, overridden per product
    localparam logic [15:0] DPSS_IDENT_DEF = 16'h5A5A;
    localparam int DPSS_CLK_PERIOD_NS = 5;
    localparam int DPSS_RUNUP_TIME_NS = 10000;
    localparam logic [10:0] DPSS_RUNUP_CYC = 11'((DPSS_RUNUP_TIME_NS
        + DPSS_CLK_PERIOD_NS - 1) / DPSS_CLK_PERIOD_NS);
    localparam logic [10:0] DPSS_CNT_RST = 11'h000;
    localparam logic [6:0] DPSS_ADDR_RST = 7'h7E;
    localparam logic [7:0] DPSS_BYTES_RST = 8'h00;

endpackage : dpss_pkg
`default_nettype wire

// File: verilog/dpss_accept.sv
`timescale 1ns/1ps
`default_nettype none
module dpss_accept (
    input wire dpss_pkg::dpss_state_e state,
    input wire dpss_pkg::dpss_kind_e kind,
    input wire logic class2,
    output logic allow
);
    import dpss_pkg::*;

    wire logic in_pon = (state == DPSS_ST_PON);
    wire logic in_wprm = (state == DPSS_ST_WPRM);
    wire logic in_wcfg = (state == DPSS_ST_WCFG);
    wire logic in_dxch = (state == DPSS_ST_DXCH);
    wire logic k_getcfg = (kind == DPSS_TK_GET_CFG);
    wire logic k_setadr = (kind == DPSS_TK_SET_ADR);
    wire logic k_prm = (kind == DPSS_TK_SET_PRM);
    wire logic k_chk = (kind == DPSS_TK_CHK_CFG);
    wire logic k_cyclic = (kind == DPSS_TK_DATA) || (kind == DPSS_TK_RD_INP)
        || (kind == DPSS_TK_RD_OUTP) || (kind == DPSS_TK_GLOBAL)
        || (kind == DPSS_TK_DIAG);

    wire logic a_adr = k_setadr && class2 && in_pon;
    wire logic a_prm = k_prm && (in_wprm || in_wcfg || in_dxch);
    wire logic a_chk = k_chk && (in_wcfg || in_dxch);
    wire logic a_cyc = k_cyclic && in_dxch;

    // config query works in every state, including mid-check
    assign allow = k_getcfg || a_adr || a_prm || a_chk || a_cyc;

endmodule : dpss_accept
`default_nettype wire

// File: verilog/dpss_slave_fsm.sv
// Notes on behaviour
// - set-address from class 2 master taken only in power-on state
// - station address written to non-volatile store, reloaded after reset
// - after run-up the slave enters wait-parameter state
// - wait-parameter takes only parameter and config query; no data
// - parameter telegram must carry standard fields; user bytes optional
// - configuration gives input and output byte counts used for exchange
// - received configuration handed to application; correct/incorrect/adapt
// - config query answered in every state
// - data exchange only after parameters and configuration accepted
// - data exchange state accepts cyclic, diag, global, check, prm, query
`timescale 1ns/1ps
`default_nettype none
module dpss_slave_fsm #(
    parameter logic [15:0] IDENT = dpss_pkg::DPSS_IDENT_DEF
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire dpss_pkg::dpss_tlg_s tlg,
    input wire logic [6:0] nv_addr_in,
    input wire logic chk_done,
    input wire dpss_pkg::dpss_chk_e chk_result,
    output dpss_pkg::dpss_state_e state,
    output logic [6:0] station_addr,
    output logic nv_wr,
    output dpss_pkg::dpss_rsp_s rsp,
    output dpss_pkg::dpss_cfg_s cfg_reply,
    output logic chk_req,
    output logic [7:0] chk_in_bytes,
    output logic [7:0] chk_out_bytes,
    output logic dx_go,
    output logic [7:0] dx_in_bytes,
    output logic [7:0] dx_out_bytes,
    output logic [15:0] wd_time,
    output logic sync_cap,
    output logic freeze_cap,
    output logic [7:0] user_prm_len
);
    import dpss_pkg::*;

    dpss_state_e state_reg, state_next;
    logic [10:0] cnt_reg;
    logic load_reg;
    logic [6:0] addr_reg;
    logic nv_wr_reg;
    dpss_rsp_s rsp_reg;
    dpss_cfg_s cfg_rd_reg;
    logic [7:0] in_reg, out_reg;
    logic [7:0] pend_in_reg, pend_out_reg;
    logic chk_req_reg, dx_go_reg;
    logic [15:0] wd_reg;
    logic sync_reg, freeze_reg;
    logic [7:0] ulen_reg;
    logic allow;

    dpss_accept u_accept (
        .state(state_reg),
        .kind(tlg.kind),
        .class2(tlg.class2),
        .allow(allow)
    );

    wire logic k_prm = (tlg.kind == DPSS_TK_SET_PRM);
    wire logic k_chk = (tlg.kind == DPSS_TK_CHK_CFG);
    wire logic k_adr = (tlg.kind == DPSS_TK_SET_ADR);
    wire logic k_get = (tlg.kind == DPSS_TK_GET_CFG);
    wire logic k_data = (tlg.kind == DPSS_TK_DATA);
    wire logic in_dxch = (state_reg == DPSS_ST_DXCH);
    wire logic in_chk = (state_reg == DPSS_ST_CHK);
    // short or foreign parameter sets are refused outright
    wire logic prm_ok = (tlg.prm_len >= DPSS_PRM_MIN_LEN)
        && (tlg.ident == IDENT);
    wire logic cfg_match = (tlg.in_bytes == in_reg)
        && (tlg.out_bytes == out_reg);
    wire logic take = tlg.valid && allow
        && (!k_prm || prm_ok)
        && (!k_chk || !in_dxch || cfg_match);
    wire logic prm_take = take && k_prm;
    wire logic chk_take = take && k_chk && !in_dxch;
    wire logic adr_take = take && k_adr;
    wire logic dx_take = take && k_data && in_dxch;
    wire logic runup_done = (cnt_reg == DPSS_RUNUP_CYC);
    wire logic chk_bad = in_chk && chk_done
        && (chk_result == DPSS_CR_INCORRECT);
    wire logic chk_good = in_chk && chk_done && !chk_bad;
    // refused prm or mismatching check drops a running exchange
    wire logic dx_drop = in_dxch && tlg.valid
        && ((k_prm && !prm_ok) || (k_chk && !cfg_match));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DPSS_ST_PON: begin
                if (runup_done) begin
                    state_next = DPSS_ST_WPRM;
                end
            end
            DPSS_ST_WPRM: begin
                if (prm_take) begin
                    state_next = DPSS_ST_WCFG;
                end
            end
            DPSS_ST_WCFG: begin
                if (chk_take) begin
                    state_next = DPSS_ST_CHK;
                end else if (tlg.valid && k_prm && !prm_ok) begin
                    state_next = DPSS_ST_WPRM;
                end
            end
            DPSS_ST_CHK: begin
                if (chk_bad) begin
                    state_next = DPSS_ST_WPRM;
                end else if (chk_good) begin
                    state_next = DPSS_ST_DXCH;
                end
            end
            DPSS_ST_DXCH: begin
                if (dx_drop) begin
                    state_next = DPSS_ST_WPRM;
                end
            end
            default: begin
                state_next = DPSS_ST_WPRM;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= DPSS_ST_PON;
            cnt_reg <= DPSS_CNT_RST;
        end else begin
            state_reg <= state_next;
            if (!runup_done) begin
                cnt_reg <= cnt_reg + 11'h001;
            end
        end
    end

    // nv value is caught one edge after release, never under reset
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            load_reg <= 1'b1;
            addr_reg <= DPSS_ADDR_RST;
            nv_wr_reg <= 1'b0;
        end else begin
            load_reg <= 1'b0;
            nv_wr_reg <= adr_take;
            if (adr_take) begin
                addr_reg <= tlg.new_addr;
            end else if (load_reg) begin
                addr_reg <= nv_addr_in;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rsp_reg <= '0;
            cfg_rd_reg <= '0;
        end else begin
            rsp_reg <= '{valid: tlg.valid, accepted: take, kind: tlg.kind};
            cfg_rd_reg.valid <= tlg.valid && k_get;
            cfg_rd_reg.in_bytes <= in_reg;
            cfg_rd_reg.out_bytes <= out_reg;
        end
    end

    // counts held pending until the application approves them
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            in_reg <= DPSS_BYTES_RST;
            out_reg <= DPSS_BYTES_RST;
            pend_in_reg <= DPSS_BYTES_RST;
            pend_out_reg <= DPSS_BYTES_RST;
            chk_req_reg <= 1'b0;
        end else begin
            chk_req_reg <= chk_take;
            if (chk_take) begin
                pend_in_reg <= tlg.in_bytes;
                pend_out_reg <= tlg.out_bytes;
            end
            if (chk_good) begin
                in_reg <= pend_in_reg;
                out_reg <= pend_out_reg;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dx_go_reg <= 1'b0;
            wd_reg <= 16'h0000;
            sync_reg <= 1'b0;
            freeze_reg <= 1'b0;
            ulen_reg <= 8'h00;
        end else begin
            dx_go_reg <= dx_take;
            if (prm_take) begin
                wd_reg <= tlg.wd_time;
                sync_reg <= tlg.sync_cap;
                freeze_reg <= tlg.freeze_cap;
                ulen_reg <= tlg.prm_len - DPSS_PRM_MIN_LEN;
            end
        end
    end

    assign state = state_reg;
    assign station_addr = addr_reg;
    assign nv_wr = nv_wr_reg;
    assign rsp = rsp_reg;
    assign cfg_reply = cfg_rd_reg;
    assign chk_req = chk_req_reg;
    assign chk_in_bytes = pend_in_reg;
    assign chk_out_bytes = pend_out_reg;
    assign dx_go = dx_go_reg;
    assign dx_in_bytes = in_reg;
    assign dx_out_bytes = out_reg;
    assign wd_time = wd_reg;
    assign sync_cap = sync_reg;
    assign freeze_cap = freeze_reg;
    assign user_prm_len = ulen_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_adr_in_pon;
        tlg.valid && k_adr && tlg.class2 && (state_reg == DPSS_ST_PON);
    endsequence
    property p_adr_pon_only;
        nv_wr |-> $past(state_reg) == DPSS_ST_PON;
    endproperty
    a_adr_pon_only: assert property (p_adr_pon_only)
        else $error("address changed outside power-on");
    property p_adr_store;
        s_adr_in_pon |=> nv_wr && (station_addr == $past(tlg.new_addr));
    endproperty
    a_adr_store: assert property (p_adr_store)
        else $error("set-address not stored");
    property p_runup;
        (state_reg != DPSS_ST_PON) && ($past(state_reg) == DPSS_ST_PON)
            |-> (state_reg == DPSS_ST_WPRM)
            && ($past(cnt_reg) == DPSS_RUNUP_CYC);
    endproperty
    a_runup: assert property (p_runup)
        else $error("run-up exit wrong");
    property p_wprm_no_data;
        (state_reg == DPSS_ST_WPRM) && tlg.valid && !k_prm && !k_get
            |=> rsp.valid && !rsp.accepted && !dx_go;
    endproperty
    a_wprm_no_data: assert property (p_wprm_no_data)
        else $error("wait-prm accepted a foreign telegram");
    property p_prm_short;
        tlg.valid && k_prm && (tlg.prm_len < DPSS_PRM_MIN_LEN)
            |=> !rsp.accepted;
    endproperty
    a_prm_short: assert property (p_prm_short)
        else $error("short parameter set accepted");
    property p_dx_counts;
        chk_good |=> in_dxch && (dx_in_bytes == $past(chk_in_bytes))
            && (dx_out_bytes == $past(chk_out_bytes));
    endproperty
    a_dx_counts: assert property (p_dx_counts)
        else $error("approved counts not taken over");
    property p_dx_state;
        dx_go |-> $past(in_dxch) && ($past(tlg.kind) == DPSS_TK_DATA);
    endproperty
    a_dx_state: assert property (p_dx_state)
        else $error("exchange outside data state");
    sequence s_cfg_in_wcfg;
        tlg.valid && k_chk && (state_reg == DPSS_ST_WCFG);
    endsequence
    property p_chk_req;
        s_cfg_in_wcfg |=> chk_req && (chk_in_bytes == $past(tlg.in_bytes))
            && (state_reg == DPSS_ST_CHK);
    endproperty
    a_chk_req: assert property (p_chk_req)
        else $error("configuration not handed over");
    property p_get_cfg;
        tlg.valid && k_get |=> rsp.accepted && cfg_reply.valid;
    endproperty
    a_get_cfg: assert property (p_get_cfg)
        else $error("config query refused");
    property p_dxch_accept;
        in_dxch && tlg.valid && !k_prm && !k_chk && !k_adr |=> rsp.accepted;
    endproperty
    a_dxch_accept: assert property (p_dxch_accept)
        else $error("data state refused a cyclic telegram");
    property p_chk_bad;
        chk_bad |=> (state_reg == DPSS_ST_WPRM) ##1 !dx_go;
    endproperty
    a_chk_bad: assert property (p_chk_bad)
        else $error("incorrect configuration not handled");

endmodule : dpss_slave_fsm
`default_nettype wire

// File: tb/dpss_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpss_master_model (
    input wire logic core_clk,
    output dpss_pkg::dpss_tlg_s tlg
);
    import dpss_pkg::*;
    localparam int TW = $bits(dpss_tlg_s);

    initial begin
        tlg = '0;
    end

    // one telegram word per call, taken at the second edge
    task automatic send(input dpss_kind_e k, input logic c2,
            input logic [7:0] a, input logic [7:0] b,
            input logic [7:0] len, input logic [15:0] id);
        dpss_tlg_s w;
        w = '{valid: 1'b1, kind: k, class2: c2, new_addr: a[6:0],
            in_bytes: a, out_bytes: b, ident: id, sync_cap: 1'b1,
            freeze_cap: 1'b0, wd_time: 16'h0123, prm_len: len};
        @(posedge core_clk);
        tlg <= w;
        @(posedge core_clk);
        // idle word inverts the fields so stale data cannot pass
        tlg <= {1'b0, ~w[TW-2:0]};
    endtask : send
endmodule : dpss_master_model
`default_nettype wire

// File: tb/tb_dp_slave_state_machine.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    mismatches++; \
    $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module tb_dp_slave_state_machine;
    import dpss_pkg::*;
    logic core_clk;
    logic rst_b;
    dpss_tlg_s tlg;
    logic [6:0] nv_mem = 7'h33;
    logic chk_done;
    dpss_chk_e chk_result;
    dpss_state_e state;
    logic [6:0] station_addr;
    logic nv_wr;
    dpss_rsp_s rsp;
    dpss_cfg_s cfg_reply;
    logic chk_req;
    logic [7:0] chk_in_bytes;
    logic [7:0] chk_out_bytes;
    logic dx_go;
    logic [7:0] dx_in_bytes;
    logic [7:0] dx_out_bytes;
    logic [15:0] wd_time;
    logic sync_cap;
    logic freeze_cap;
    logic [7:0] user_prm_len;
    int mismatches;
    int n_checks;

    dpss_slave_fsm dut_u (.core_clk(core_clk), .rst_b(rst_b), .tlg(tlg),
        .nv_addr_in(nv_mem), .chk_done(chk_done), .chk_result(chk_result),
        .state(state), .station_addr(station_addr), .nv_wr(nv_wr),
        .rsp(rsp), .cfg_reply(cfg_reply), .chk_req(chk_req),
        .chk_in_bytes(chk_in_bytes), .chk_out_bytes(chk_out_bytes),
        .dx_go(dx_go), .dx_in_bytes(dx_in_bytes),
        .dx_out_bytes(dx_out_bytes), .wd_time(wd_time),
        .sync_cap(sync_cap), .freeze_cap(freeze_cap),
        .user_prm_len(user_prm_len));
    dpss_master_model master_u (.core_clk(core_clk), .tlg(tlg));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // non-volatile store survives the bench's resets
    always @(posedge core_clk) begin
        if (nv_wr === 1'b1) nv_mem <= station_addr;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic do_reset;
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1;
    endtask : do_reset

    task automatic tx(input dpss_kind_e k, input logic c2,
            input logic [7:0] a, input logic [7:0] b,
            input logic [7:0] len, input logic acc);
        master_u.send(k, c2, a, b, len, DPSS_IDENT_DEF);
        #1;
        `CHK("rsp.valid", 1'b1, rsp.valid)
        `CHK("rsp.accepted", acc, rsp.accepted)
        `CHK("rsp.kind", k, rsp.kind)
    endtask : tx

    task automatic chk(input dpss_chk_e r);
        @(posedge core_clk);
        chk_done <= 1'b1;
        chk_result <= r;
        @(posedge core_clk);
        chk_done <= 1'b0;
        #1;
    endtask : chk

    task automatic t_power_on;
        `CHK("station_addr", 7'h33, station_addr)
        `CHK("state", DPSS_ST_PON, state)
        tx(DPSS_TK_SET_ADR, 1'b0, 8'h15, 8'h00, 8'h00, 1'b0);
        tx(DPSS_TK_SET_ADR, 1'b1, 8'h15, 8'h00, 8'h00, 1'b1);
        `CHK("nv_wr", 1'b1, nv_wr)
        `CHK("station_addr", 7'h15, station_addr)
        tx(DPSS_TK_DATA, 1'b0, 8'h02, 8'h03, 8'h00, 1'b0);
        tx(DPSS_TK_GET_CFG, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1);
        `CHK("cfg_reply", 17'h10000, cfg_reply)
    endtask : t_power_on

    task automatic t_runup;
        int n;
        n = 0;
        while (state !== DPSS_ST_WPRM && n < 2100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHK("run-up length ok", 1'b1, n > 1950 && n < 2005)
    endtask : t_runup

    task automatic t_wait_prm;
        for (int k = 0; k < 6; k++) begin
            tx(dpss_kind_e'(k), 1'b1, 8'h02, 8'h03, 8'h00, 1'b0);
            `CHK("dx_go", 1'b0, dx_go)
        end
        tx(DPSS_TK_SET_ADR, 1'b1, 8'h2A, 8'h00, 8'h00, 1'b0);
        `CHK("station_addr", 7'h15, station_addr)
        tx(DPSS_TK_GET_CFG, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1);
        `CHK("state", DPSS_ST_WPRM, state)
        tx(DPSS_TK_SET_PRM, 1'b0, 8'h00, 8'h00, 8'h06, 1'b0);
        tx(DPSS_TK_SET_PRM, 1'b0, 8'h00, 8'h00, 8'h09, 1'b1);
        `CHK("state", DPSS_ST_WCFG, state)
        `CHK("wd_time", 16'h0123, wd_time)
        `CHK("caps", 2'b10, {sync_cap, freeze_cap})
        `CHK("user_prm_len", 8'h02, user_prm_len)
    endtask : t_wait_prm

    task automatic t_cfg_bad;
        master_u.send(DPSS_TK_SET_PRM, 1'b0, 8'h00, 8'h00, 8'h09,
            ~DPSS_IDENT_DEF);
        #1;
        `CHK("foreign prm", 1'b0, rsp.accepted)
        `CHK("state", DPSS_ST_WPRM, state)
        tx(DPSS_TK_SET_PRM, 1'b0, 8'h00, 8'h00, 8'h09, 1'b1);
        tx(DPSS_TK_CHK_CFG, 1'b0, 8'h02, 8'h03, 8'h00, 1'b1);
        `CHK("chk_req", 1'b1, chk_req)
        `CHK("chk bytes", 16'h0203, {chk_in_bytes, chk_out_bytes})
        `CHK("state", DPSS_ST_CHK, state)
        tx(DPSS_TK_DATA, 1'b0, 8'h02, 8'h03, 8'h00, 1'b0);
        chk(DPSS_CR_INCORRECT);
        `CHK("state", DPSS_ST_WPRM, state)
        `CHK("dx bytes", 16'h0000, {dx_in_bytes, dx_out_bytes})
    endtask : t_cfg_bad

    task automatic t_cfg_ok(input logic [7:0] i, input logic [7:0] o,
            input dpss_chk_e r);
        tx(DPSS_TK_SET_PRM, 1'b0, 8'h00, 8'h00, 8'h09, 1'b1);
        tx(DPSS_TK_CHK_CFG, 1'b0, i, o, 8'h00, 1'b1);
        chk(r);
        `CHK("state", DPSS_ST_DXCH, state)
        `CHK("dx bytes", {i, o}, {dx_in_bytes, dx_out_bytes})
    endtask : t_cfg_ok

    task automatic t_dxch;
        for (int k = 0; k < 8; k++) begin
            tx(dpss_kind_e'(k), 1'b0, 8'h04, 8'h05, 8'h09, 1'b1);
        end
        `CHK("state", DPSS_ST_DXCH, state)
        tx(DPSS_TK_DATA, 1'b0, 8'h04, 8'h05, 8'h00, 1'b1);
        `CHK("dx_go", 1'b1, dx_go)
        tx(DPSS_TK_GET_CFG, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1);
        `CHK("cfg_reply", 17'h10405, cfg_reply)
        tx(DPSS_TK_SET_ADR, 1'b1, 8'h2A, 8'h00, 8'h00, 1'b0);
        tx(DPSS_TK_CHK_CFG, 1'b0, 8'h06, 8'h07, 8'h00, 1'b0);
        `CHK("state", DPSS_ST_WPRM, state)
    endtask : t_dxch

    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        mismatches = 0;
        n_checks = 0;
        rst_b = 1'b0;
        chk_done = 1'b0;
        chk_result = DPSS_CR_CORRECT;
        do_reset();
        t_power_on();
        t_runup();
        t_wait_prm();
        t_cfg_bad();
        t_cfg_ok(8'h04, 8'h05, DPSS_CR_ADAPTABLE);
        t_dxch();
        t_cfg_ok(8'h02, 8'h03, DPSS_CR_CORRECT);
        do_reset();
        `CHK("station_addr", 7'h15, station_addr)
        report_and_stop();
    end
endmodule : tb_dp_slave_state_machine
`default_nettype wire
